// File: hw/larc_delay.sv
// Retriggerable delay: level rises a fixed count of cycles after the last restart
module larc_delay
    import larc_pkg::*;
#(
    parameter int unsigned CYCLES = STANDSTILL_CYCLES
)(
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic restart,
    output logic      expired
);

    localparam int unsigned W = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } larc_dly_type;

    larc_dly_type s_ff;
    larc_dly_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (restart) begin
            nxt_s.cnt  = '0;
            nxt_s.done = 1'b0;
        end else if (!s_ff.done) begin
            nxt_s.cnt  = s_ff.cnt + W'(1);
            nxt_s.done = (s_ff.cnt == W'(CYCLES - 1));                  // R15
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign expired = s_ff.done;

    chk_stand_restart: assert property (@(posedge CLK) disable iff (RESET) // R15
        restart |=> !expired)
        else $error("standstill not cleared by a step");

endmodule : larc_delay

// File: hw/larc_thresh.sv
// Load threshold compare for the current regulator
module larc_thresh
    import larc_pkg::*;
(
    input  wire logic [THR_W-1:0]  lower,
    input  wire logic [THR_W-1:0]  distance,
    input  wire logic [READ_W-1:0] reading,
    output logic                   disabled,
    output logic                   below,
    output logic                   above
);

    logic [10:0] lower_thr;
    logic [10:0] upper_thr;
    logic [5:0]  upper_sum;

    always_comb begin
        disabled  = (lower == '0);                                     // R2
        lower_thr = 11'({lower, 5'h00});                               // R1
        upper_sum = 6'({2'b00, lower}) + 6'({2'b00, distance}) + 6'h01;
        upper_thr = 11'(upper_sum) << THR_SHIFT;                       // R3
        below     = !disabled && (11'(reading) < lower_thr);           // R1
        above     = !disabled && (11'(reading) > upper_thr);           // R3
    end

endmodule : larc_thresh

// File: hw/larc_top.sv
// Load-adaptive current regulator with start-up lock, clock select and standstill
//
// How it works
// [R1] Lower threshold is lower field times 32; readings below it raise current.
// [R2] Lower field zero switches the adaptive regulation off, current sits at scale.
// [R3] Upper threshold is (lower plus distance plus 1) times 32; above it lowers.
// [R4] Each low reading adds 1, 2, 4 or 8 per increment field.
// [R5] Decrement by one after 32, 8, 2 or 1 consecutive high readings.
// [R6] Decrement field codes 0,1,2,3 mean 32, 8, 2, 1 readings.
// [R7] Current never below half scale, or quarter scale with minimum select set.
// [R8] Current never above the programmed current scale.
// [R9] Actual current shown as five-bit value, code n means (n+1)/32.
// [R10] Regulation acts once per new reading and holds value in between.
// [R11] Controller should turn regulation off at low speed with fixed current.
// [R12] During start-up the management unit is held and all configuration cleared.
// [R13] Internal oscillator nominal 15 MHz; external clock 10 to 20 MHz accepted.
// [R14] First high level on clock input selects the external clock for good.
// [R15] Standstill flag rises a fixed clock-count after the last step input.
// [R16] Enabled short-to-ground detection works without any clock.
// [R17] Controller must disable the drive before stopping an external clock.
// [R18] New reading every two full steps, or every six with filtering.
// [R19] Load reading is unsigned 0 to 1023, higher means lighter load.
module larc_top
    import larc_pkg::*;
#(
    parameter int unsigned STANDSTILL_DELAY = STANDSTILL_CYCLES
)(
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    input  wire logic                  CFG_WRITE,
    input  wire larc_cfg_type          CFG_IN,
    input  wire logic                  FULL_STEP,
    input  wire logic [READ_W-1:0]     LOAD_SAMPLE,
    input  wire logic                  STEP_IN,
    input  wire logic                  EXT_CLK_IN,
    input  wire logic                  SHORT_DET_ENABLE,
    input  wire logic                  SHORT_SENSE,
    output larc_cfg_type               CFG_OUT,
    output logic                       MGMT_READY,
    output logic [READ_W-1:0]          LOAD_READING,
    output logic                       LOAD_READING_VALID,
    output logic [CUR_W-1:0]           ACTUAL_CURRENT_VALUE,
    output logic                       CLOCK_EXT_SEL,
    output logic                       STANDSTILL,
    output logic                       SHORT_TO_GND
);

    typedef struct packed {
        larc_st_type        st;
        logic [4:0]         start_cnt;
        larc_cfg_type       cfg;
        logic [1:0]         step_cnt;
        logic [1:0]         filt_cnt;
        logic [11:0]        filt_sum;
        logic [READ_W-1:0]  reading;
        logic               reading_vld;
        logic [CUR_W-1:0]   cur;
        logic [4:0]         dn_cnt;
        logic               ext_sel;
    } larc_state_type;

    larc_state_type s_ff;
    larc_state_type nxt_s;

    logic             thr_disabled;
    logic             thr_below;
    logic             thr_above;
    logic [5:0]       scale6;
    logic [5:0]       min6;
    logic [CUR_W-1:0] min_code;
    logic [5:0]       inc6;
    logic [5:0]       sum6;
    logic [4:0]       dec_lim;
    logic [11:0]      acc;
    logic [27:0]      prod;

    ////////////////////////////////////////////////////////////////////////////
    // Threshold compare and standstill timer

    larc_thresh u_thresh (
        .lower    (s_ff.cfg.lower_load_threshold),
        .distance (s_ff.cfg.threshold_distance),
        .reading  (s_ff.reading),
        .disabled (thr_disabled),
        .below    (thr_below),
        .above    (thr_above)
    );

    larc_delay #(
        .CYCLES (STANDSTILL_DELAY)
    ) u_standstill (
        .CLK     (CLK),
        .RESET   (RESET),
        .restart (STEP_IN),
        .expired (STANDSTILL)                                           // R15
    );

    ////////////////////////////////////////////////////////////////////////////
    // Current limits derived from the scale; increment step and decrement limit

    always_comb begin
        scale6   = 6'({1'b0, s_ff.cfg.current_scale}) + 6'h01;
        min6     = s_ff.cfg.minimum_current_select ? (scale6 >> 2) : (scale6 >> 1); // R7
        if (min6 == 6'h00) begin
            min6 = 6'h01;
        end
        min_code = 5'(min6 - 6'h01);                                    // R7
        inc6     = 6'h01 << s_ff.cfg.current_increment_step;            // R4
        case (s_ff.cfg.decrement_reading_count)                         // R6
            2'h0:    dec_lim = DEC_LIM_0;
            2'h1:    dec_lim = DEC_LIM_1;
            2'h2:    dec_lim = DEC_LIM_2;
            default: dec_lim = DEC_LIM_3;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_s             = s_ff;
        nxt_s.reading_vld = 1'b0;
        acc               = s_ff.filt_sum + 12'(LOAD_SAMPLE);
        prod              = 28'(acc) * 28'(DIV3_MUL);
        sum6              = 6'({1'b0, s_ff.cur}) + inc6;

        // Sticky external clock select; a grounded input never sets it
        if (EXT_CLK_IN) begin
            nxt_s.ext_sel = 1'b1;                                       // R14
        end

        case (s_ff.st)
            ST_STARTUP: begin
                // Writes are dropped so software sees a clean all-zero setup
                nxt_s.cfg       = CFG_RST;                              // R12
                nxt_s.start_cnt = s_ff.start_cnt + 5'h01;
                if (s_ff.start_cnt == STARTUP_CYCLES - 5'h01) begin
                    nxt_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (CFG_WRITE) begin
                    nxt_s.cfg = CFG_IN;
                end
            end
            default: begin
                nxt_s.st = ST_STARTUP;
            end
        endcase

        // Measurement rate: one raw value per two full steps
        if (FULL_STEP) begin                                            // R18
            nxt_s.step_cnt = s_ff.step_cnt + 2'h1;
            if (s_ff.step_cnt == STEPS_PER_READ - 2'h1) begin
                nxt_s.step_cnt = 2'h0;
                if (!s_ff.cfg.load_filter_enable) begin
                    nxt_s.reading     = LOAD_SAMPLE;                    // R19
                    nxt_s.reading_vld = 1'b1;
                    nxt_s.filt_cnt    = 2'h0;
                    nxt_s.filt_sum    = '0;
                end else if (s_ff.filt_cnt == FILTER_READS - 2'h1) begin
                    // Mean of three keeps the 0..1023 range
                    nxt_s.reading     = prod[DIV3_SHIFT +: READ_W];     // R18
                    nxt_s.reading_vld = 1'b1;
                    nxt_s.filt_cnt    = 2'h0;
                    nxt_s.filt_sum    = '0;
                end else begin
                    nxt_s.filt_cnt    = s_ff.filt_cnt + 2'h1;
                    nxt_s.filt_sum    = acc;
                end
            end
        end

        // Regulation: acts only on the cycle after a new reading
        if (thr_disabled) begin
            nxt_s.cur    = s_ff.cfg.current_scale;                      // R2
            nxt_s.dn_cnt = '0;
        end else if (s_ff.reading_vld) begin                            // R10
            if (thr_below) begin
                nxt_s.dn_cnt = '0;
                nxt_s.cur    = 5'(sum6 > 6'(s_ff.cfg.current_scale) ?   // R4
                               6'(s_ff.cfg.current_scale) : sum6);      // R8
            end else if (thr_above) begin
                if (s_ff.dn_cnt >= dec_lim) begin                       // R5
                    nxt_s.dn_cnt = '0;
                    if (s_ff.cur > min_code) begin
                        nxt_s.cur = s_ff.cur - 5'h01;                   // R5
                    end
                end else begin
                    nxt_s.dn_cnt = s_ff.dn_cnt + 5'h01;
                end
            end else begin
                // Readings in the band break the run of high readings
                nxt_s.dn_cnt = '0;
            end
        end

        // Scale changes between readings still pull the value inside its limits
        if (!thr_disabled) begin
            if (nxt_s.cur > s_ff.cfg.current_scale) begin
                nxt_s.cur = s_ff.cfg.current_scale;                     // R8
            end else if (nxt_s.cur < min_code) begin
                nxt_s.cur = min_code;                                   // R7
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s_ff     <= '0;
            s_ff.st  <= ST_STARTUP;                                     // R12
            s_ff.cur <= CUR_RST;
            s_ff.cfg <= CFG_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign CFG_OUT              = s_ff.cfg;
    assign MGMT_READY           = (s_ff.st == ST_RUN);                  // R12
    assign LOAD_READING         = s_ff.reading;                         // R19
    assign LOAD_READING_VALID   = s_ff.reading_vld;
    assign ACTUAL_CURRENT_VALUE = s_ff.cur;                             // R9
    assign CLOCK_EXT_SEL        = s_ff.ext_sel;                         // R13
    // Pure gating so the fault path needs no clock edge
    assign SHORT_TO_GND         = SHORT_DET_ENABLE & SHORT_SENSE;       // R16

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_cur_max: assert property (@(posedge CLK) disable iff (RESET) // R8
        $stable(s_ff.cfg) |-> s_ff.cur <= s_ff.cfg.current_scale)
        else $error("current above scale");

    chk_cur_min: assert property (@(posedge CLK) disable iff (RESET) // R7
        ($stable(s_ff.cfg) && !thr_disabled) |-> s_ff.cur >= min_code)
        else $error("current below minimum");

    chk_off_full: assert property (@(posedge CLK) disable iff (RESET) // R2
        ($stable(s_ff.cfg) && s_ff.cfg.lower_load_threshold == '0)
        |-> s_ff.cur == s_ff.cfg.current_scale)
        else $error("disabled regulator not at scale");

    chk_inc_step: assert property (@(posedge CLK) disable iff (RESET) // R4
        (s_ff.reading_vld && thr_below && !CFG_WRITE
         && sum6 <= 6'(s_ff.cfg.current_scale))
        |=> s_ff.cur == $past(5'(sum6)))
        else $error("increment step wrong");

    chk_dec_run: assert property (@(posedge CLK) disable iff (RESET) // R5
        (s_ff.reading_vld && thr_above && s_ff.dn_cnt < dec_lim && !CFG_WRITE)
        |=> $stable(s_ff.cur))
        else $error("decrement before run complete");

    chk_dec_one: assert property (@(posedge CLK) disable iff (RESET) // R5
        (s_ff.reading_vld && thr_above && s_ff.dn_cnt >= dec_lim
         && s_ff.cur > min_code && !CFG_WRITE)
        |=> s_ff.cur == $past(s_ff.cur) - 5'h01)
        else $error("decrement not by one");

    chk_hold_idle: assert property (@(posedge CLK) disable iff (RESET) // R10
        (!s_ff.reading_vld && $stable(s_ff.cfg) && !CFG_WRITE) |=> $stable(s_ff.cur))
        else $error("current moved without reading");

    chk_start_lock: assert property (@(posedge CLK) disable iff (RESET) // R12
        (s_ff.st == ST_STARTUP) |=> s_ff.cfg == CFG_RST)
        else $error("configuration taken during start-up");

    chk_ext_sticky: assert property (@(posedge CLK) disable iff (RESET) // R14
        (EXT_CLK_IN || CLOCK_EXT_SEL) |=> CLOCK_EXT_SEL)
        else $error("external clock select lost");

    chk_raw_rate: assert property (@(posedge CLK) disable iff (RESET) // R18
        (FULL_STEP && s_ff.step_cnt == 2'h0) |=> !s_ff.reading_vld)
        else $error("reading after a single step");

    chk_off_run: assert property (@(posedge CLK) disable iff (RESET) // R2
        thr_disabled |=> s_ff.dn_cnt == '0)
        else $error("run count kept while regulation off");

    chk_band_hold: assert property (@(posedge CLK) disable iff (RESET) // R10
        (s_ff.reading_vld && !thr_disabled && !thr_below && !thr_above
         && $stable(s_ff.cfg)) |=> ($stable(s_ff.cur) && s_ff.dn_cnt == '0))
        else $error("band reading moved the current");

    chk_cfg_take: assert property (@(posedge CLK) disable iff (RESET) // R12
        (MGMT_READY && CFG_WRITE) |=> s_ff.cfg == $past(CFG_IN))
        else $error("configuration write not taken");

    chk_valid_pulse: assert property (@(posedge CLK) disable iff (RESET) // R18
        s_ff.reading_vld |=> !s_ff.reading_vld)
        else $error("reading flagged on two cycles");

    chk_filt_rate: assert property (@(posedge CLK) disable iff (RESET) // R18
        (FULL_STEP && s_ff.step_cnt == 2'h1 && s_ff.cfg.load_filter_enable
         && s_ff.filt_cnt != FILTER_READS - 2'h1) |=> !s_ff.reading_vld)
        else $error("filtered reading before three samples");

    chk_read_take: assert property (@(posedge CLK) disable iff (RESET) // R19
        (FULL_STEP && s_ff.step_cnt == 2'h1 && !s_ff.cfg.load_filter_enable)
        |=> (s_ff.reading_vld && s_ff.reading == $past(LOAD_SAMPLE)))
        else $error("raw reading not taken");

endmodule : larc_top

// File: pkg/larc_pkg.sv
// Shared constants and types of the load-adaptive current regulator
package larc_pkg;

    // Clock and oscillator figures
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned INT_OSC_HZ      = 15_000_000;
    localparam int unsigned EXT_CLK_MIN_HZ  = 10_000_000;
    localparam int unsigned EXT_CLK_MAX_HZ  = 20_000_000;

    // Field widths
    localparam int unsigned THR_W           = 4;
    localparam int unsigned CUR_W           = 5;
    localparam int unsigned READ_W          = 10;

    // Threshold scaling: thresholds are field times 32
    localparam int unsigned THR_SHIFT       = 5;

    // Full steps per raw load measurement, and raw readings per filtered one
    localparam logic [1:0]  STEPS_PER_READ  = 2'h2;
    localparam logic [1:0]  FILTER_READS    = 2'h3;
    // Divide by three as multiply by 21846 then shift right by 16
    localparam logic [15:0] DIV3_MUL        = 16'h5556;
    localparam int unsigned DIV3_SHIFT      = 16;

    // Decrement limits (count minus one) for field codes 0..3: 32, 8, 2, 1 readings
    localparam logic [4:0]  DEC_LIM_0       = 5'h1F;
    localparam logic [4:0]  DEC_LIM_1       = 5'h07;
    localparam logic [4:0]  DEC_LIM_2       = 5'h01;
    localparam logic [4:0]  DEC_LIM_3       = 5'h00;

    // Start-up hold of the management unit, in clock cycles
    localparam logic [4:0]  STARTUP_CYCLES  = 5'h10;
    // Standstill delay after the last step input, in clock cycles
    localparam int unsigned STANDSTILL_CYCLES = 1_048_576;

    // Reset values
    localparam logic [4:0]  CUR_RST         = 5'h00;

    typedef struct packed {
        logic [THR_W-1:0]  lower_load_threshold;
        logic [THR_W-1:0]  threshold_distance;
        logic [1:0]        current_increment_step;
        logic [1:0]        decrement_reading_count;
        logic              minimum_current_select;
        logic [CUR_W-1:0]  current_scale;
        logic              load_filter_enable;
    } larc_cfg_type;

    localparam larc_cfg_type CFG_RST = '0;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN     = 2'b01
    } larc_st_type;

endpackage : larc_pkg

// File: verif/larc_motor_model.sv
// Behavioural power stage and motor: full-step pulses carrying load samples
module larc_motor_model
    import larc_pkg::*;
(
    input  wire logic              clk,
    output logic                   full_step,
    output logic [READ_W-1:0]      load_sample
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        full_step   = 1'b0;
        load_sample = 10'h000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two full steps per raw sample; gap cycles between them model a slow motor
    task automatic step_pair(input logic [READ_W-1:0] s, input int gap);
        @(negedge clk);
        full_step   = 1'b1;
        load_sample = ~s;
        repeat (gap) begin
            @(negedge clk);
            full_step = 1'b0;
        end
        @(negedge clk);
        full_step   = 1'b1;
        load_sample = s;
        @(negedge clk);
        full_step   = 1'b0;
        // Sample no longer valid: show its inverse so a late capture is caught
        load_sample = ~s;
    endtask : step_pair
endmodule : larc_motor_model

// File: verif/tb_top.sv
// Self-checking bench of the load-adaptive current regulator
module tb_top
    import larc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned DELAY = 20;
    logic               clk;
    logic               clk_run;
    logic               reset;
    logic               cfg_write;
    larc_cfg_type       cfg_in;
    logic               step_in;
    logic               ext_clk_in;
    logic               short_en;
    logic               short_sense;
    logic               full_step;
    logic [READ_W-1:0]  load_sample;
    larc_cfg_type       cfg_out;
    logic               mgmt_ready;
    logic [READ_W-1:0]  load_reading;
    logic               load_valid;
    logic [CUR_W-1:0]   actual;
    logic               ext_sel;
    logic               standstill;
    logic               short_gnd;
    int                 failures;
    int                 check_count;
    int                 valid_cnt;
    int                 exp_cur;
    int                 run;
    larc_cfg_type       cfg;

    larc_top #(.STANDSTILL_DELAY(DELAY)) uut (
        .CLK(clk), .RESET(reset), .CFG_WRITE(cfg_write), .CFG_IN(cfg_in),
        .FULL_STEP(full_step), .LOAD_SAMPLE(load_sample), .STEP_IN(step_in),
        .EXT_CLK_IN(ext_clk_in), .SHORT_DET_ENABLE(short_en), .SHORT_SENSE(short_sense),
        .CFG_OUT(cfg_out), .MGMT_READY(mgmt_ready), .LOAD_READING(load_reading),
        .LOAD_READING_VALID(load_valid), .ACTUAL_CURRENT_VALUE(actual),
        .CLOCK_EXT_SEL(ext_sel), .STANDSTILL(standstill), .SHORT_TO_GND(short_gnd)
    );
    larc_motor_model motor (.clk(clk), .full_step(full_step), .load_sample(load_sample));

    ////////////////////////////////////////////////////////////////////////////////
    always #20 if (clk_run) clk = ~clk;
    always @(posedge clk) if (load_valid === 1'b1) valid_cnt++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model of the regulator, kept independent of the design
    function automatic larc_cfg_type mk(input int l, d, u, n, m, s, f);
        larc_cfg_type c;
        c.lower_load_threshold    = l[THR_W-1:0];
        c.threshold_distance      = d[THR_W-1:0];
        c.current_increment_step  = u[1:0];
        c.decrement_reading_count = n[1:0];
        c.minimum_current_select  = m[0];
        c.current_scale           = s[CUR_W-1:0];
        c.load_filter_enable      = f[0];
        return c;
    endfunction : mk

    function automatic int clamp(input int v);
        int lo;
        lo = (int'(cfg.current_scale) + 1) >> (cfg.minimum_current_select ? 2 : 1);
        lo = (lo < 1 ? 1 : lo) - 1;
        if (v > int'(cfg.current_scale)) v = cfg.current_scale;
        if (v < lo) v = lo;
        return v;
    endfunction : clamp

    function automatic int lim(input logic [1:0] code);
        case (code)
            2'h0: return 31;
            2'h1: return 7;
            2'h2: return 1;
            default: return 0;
        endcase
    endfunction : lim

    task automatic write_cfg(input larc_cfg_type c);
        @(negedge clk);
        cfg_write = 1'b1;
        cfg_in    = c;
        @(negedge clk);
        cfg_write = 1'b0;
        repeat (2) @(negedge clk);
        cfg     = c;
        exp_cur = (c.lower_load_threshold == 0) ? int'(c.current_scale) : clamp(exp_cur);
        check(cfg_out, c);
        check(actual, exp_cur);
    endtask : write_cfg

    task automatic reading(input logic [READ_W-1:0] s, input int gap);
        int vc;
        int lo_t;
        int hi_t;
        vc   = valid_cnt;
        motor.step_pair(s, gap);
        repeat (2) @(negedge clk);
        lo_t = cfg.lower_load_threshold * 32;
        hi_t = (cfg.lower_load_threshold + cfg.threshold_distance + 1) * 32;
        if (cfg.lower_load_threshold == 0) begin
            exp_cur = cfg.current_scale;
            run     = 0;
        end else if (s < lo_t) begin
            exp_cur = clamp(exp_cur + (1 << cfg.current_increment_step));
            run     = 0;
        end else if (s > hi_t) begin
            if (run == lim(cfg.decrement_reading_count)) begin
                exp_cur = clamp(exp_cur - 1);
                run     = 0;
            end else begin
                run++;
            end
        end else begin
            run = 0;
        end
        check(valid_cnt - vc, 1);
        check(load_reading, s);
        check(actual, exp_cur);
    endtask : reading

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        int n;
        reset = 1'b1;
        repeat (5) @(negedge clk);
        check({cfg_out, mgmt_ready, actual, ext_sel}, 0);
        reset     = 1'b0;
        cfg_write = 1'b1;
        cfg_in    = mk(5, 5, 1, 1, 1, 31, 1);
        n = 0;
        while (mgmt_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
            if (n == 8) cfg_write = 1'b0;
        end
        check(n, 16);
        check(cfg_out, 0);
        cfg     = '0;
        exp_cur = 0;
        run     = 0;
        done("startup");
    endtask : t_startup

    task automatic t_regulate();
        // Regulation off with a fixed current, as at low motor speed
        write_cfg(mk(0, 2, 0, 3, 0, 20, 0));
        reading(10'h064, 0);
        for (int u = 0; u < 4; u++) begin
            write_cfg(mk(4, 2, u, 3, 0, 31, 0));
            reading(10'h07F, u % 2);
            reading(10'h080, 0);
        end
        for (int k = 3; k >= 0; k--) begin
            write_cfg(mk(4, 2, 0, k, 0, 31, 0));
            repeat (lim(k[1:0])) reading(10'h0E1, 0);
            reading(10'h0E0, 1);
            repeat (lim(k[1:0]) + 1) reading(10'h0E1, 1);
        end
        write_cfg(mk(4, 2, 0, 3, 1, 15, 0));
        repeat (14) reading(10'h3FF, 0);
        write_cfg(mk(4, 2, 0, 3, 0, 15, 0));
        done("regulate");
    endtask : t_regulate

    task automatic t_misc();
        repeat (3) @(negedge clk);
        check(ext_sel, 1'b0);
        ext_clk_in = 1'b1;
        @(negedge clk);
        ext_clk_in = 1'b0;
        repeat (4) @(negedge clk);
        check(ext_sel, 1'b1);
        step_in = 1'b1;
        @(negedge clk);
        step_in = 1'b0;
        // Exact end point: still low one cycle before the count runs out
        repeat (DELAY - 1) @(negedge clk);
        check(standstill, 1'b0);
        @(negedge clk);
        check(standstill, 1'b1);
        // No steps are running, so the clock may stop without losing the chopper
        clk_run = 1'b0;
        for (int i = 0; i < 4; i++) begin
            short_en    = i[0];
            short_sense = i[1];
            #100;
            check(short_gnd, i[0] & i[1]);
        end
        short_en = 1'b0;
        short_sense = 1'b0;
        clk_run  = 1'b1;
        done("misc");
    endtask : t_misc

    task automatic t_filter();
        int vc;
        write_cfg(mk(0, 0, 0, 0, 0, 10, 1));
        // Warm-up flushes stale raw samples out of the running sum
        repeat (3) motor.step_pair(10'h12C, 1);
        repeat (2) @(negedge clk);
        vc = valid_cnt;
        repeat (6) motor.step_pair(10'h12C, 0);
        repeat (3) @(negedge clk);
        check(valid_cnt - vc, 2);
        check(load_reading, 10'h12C);
        check(actual, 10);
        done("filter");
    endtask : t_filter

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        clk_run = 1'b1;
        reset = 1'b1;
        cfg_write = 1'b0;
        cfg_in = '0;
        step_in = 1'b0;
        ext_clk_in = 1'b0;
        short_en = 1'b0;
        short_sense = 1'b0;
        t_startup();
        t_regulate();
        t_misc();
        t_filter();
        t_startup();
        summarize();
    end

    initial begin
        #(20_000 * 40);
        failures++;
        summarize();
    end
endmodule : tb_top
